// >>> design/spm_port.sv
/*
  Serial peripheral port, master or slave, one byte per transfer.
  Assumes pins arrive unsynchronised; pin directions chosen by the
  port's own direction bits arrive as the *_dir inputs.
*/
`timescale 1ns/100ps
module spm_port (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic global_irq_en,
  input wire logic irq_vector_ack,
  output logic irq_req,
  input wire logic sck_dir,
  input wire logic mosi_dir,
  input wire logic miso_dir,
  input wire logic ss_dir,
  input wire logic sck_in,
  output logic sck_out,
  output logic sck_oe,
  input wire logic mosi_in,
  output logic mosi_out,
  output logic mosi_oe,
  input wire logic miso_in,
  output logic miso_out,
  output logic miso_oe,
  input wire logic ss_b_in
);

////////////////////////////////////////////////////////////////////////
  logic [3:0] sync1_ff;
  logic [3:0] sync2_ff;
  logic sck_prev_ff;
  logic [7:0] ctrl_ff;
  logic dbl_ff;
  spm_pkg::spm_mst_t state_ff;
  logic [6:0] div_ff;
  logic [3:0] edge_ff;
  logic sck_lvl_ff;
  logic [7:0] sh_ff;
  logic [7:0] nxt_sh;
  logic [2:0] cnt_ff;
  logic slv_busy_ff;
  logic [7:0] rx_buf_ff;
  logic tx_bit_ff;
  logic done_ff;
  logic write_collision_flag_ff;
  logic arm_ff;
  logic [7:0] rdata_ff;
  logic irq_ff;
  logic sck_oe_ff;
  logic mosi_oe_ff;
  logic miso_oe_ff;

  // Synchronised pins: sck, mosi, miso, select
  wire sck_s = sync2_ff[0];
  wire mosi_s = sync2_ff[1];
  wire miso_s = sync2_ff[2];
  wire ss_b_s = sync2_ff[3];

  wire en = ctrl_ff[spm_pkg::SPM_C_EN];
  wire master_select = ctrl_ff[spm_pkg::SPM_C_MASTER_SELECT];
  wire clock_polarity = ctrl_ff[spm_pkg::SPM_C_CLOCK_POLARITY];
  wire clock_phase = ctrl_ff[spm_pkg::SPM_C_CLOCK_PHASE];
  wire lsb_first = ctrl_ff[spm_pkg::SPM_C_ORDER];

  wire ctrl_wr = reg_wr && reg_addr == spm_pkg::SPM_CTRL_OFS;
  wire stat_wr = reg_wr && reg_addr == spm_pkg::SPM_STAT_OFS;
  wire stat_rd = reg_rd && reg_addr == spm_pkg::SPM_STAT_OFS;
  wire data_wr = reg_wr && reg_addr == spm_pkg::SPM_DATA_OFS;
  wire data_rd = reg_rd && reg_addr == spm_pkg::SPM_DATA_OFS;
  wire data_acc = data_wr || data_rd;

  wire run = state_ff == spm_pkg::SPM_RUN;
  wire xfer_busy = run || slv_busy_ff;
  // Select as output is plain I/O; only an input select can fault
  wire fault = en && master_select && !ss_dir && !ss_b_s;
  wire load = data_wr && !xfer_busy;
  wire start = load && en && master_select && !fault;
  wire tick = run && div_ff == 7'h00;
  wire mst_done = tick && edge_ff == spm_pkg::SPM_LAST_EDGE;
  wire slv_act = en && !master_select && !ss_b_s;
  wire sck_chg = slv_act && sck_s != sck_prev_ff;
  wire lead_ev = (tick && !edge_ff[0]) || (sck_chg && sck_s != clock_polarity);
  wire trail_ev = (tick && edge_ff[0]) || (sck_chg && sck_s == clock_polarity);
  wire sample_ev = clock_phase ? trail_ev : lead_ev;
  wire setup_ev = clock_phase ? lead_ev : trail_ev;
  wire rx_bit = master_select ? miso_s : mosi_s;
  wire slv_done = slv_act && sample_ev && cnt_ff == spm_pkg::SPM_LAST_BIT;
  wire done = mst_done || slv_done;

  always_comb begin
    nxt_sh = sh_ff;
    if (sample_ev) begin
      nxt_sh = lsb_first ? {rx_bit, sh_ff[7:1]} : {sh_ff[6:0], rx_bit};
    end
  end

////////////////////////////////////////////////////////////////////////
  // First stage feeds only the second stage
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      sync1_ff <= 4'hF;
      sync2_ff <= 4'hF;
      sck_prev_ff <= 1'b0;
    end else begin
      sync1_ff <= {ss_b_in, miso_in, mosi_in, sck_in};
      sync2_ff <= sync1_ff;
      sck_prev_ff <= sck_s;
    end
  end

  // Fault is applied after a write so the forced clear wins
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_ff <= spm_pkg::SPM_CTRL_RST;
      dbl_ff <= spm_pkg::SPM_STAT_RST[spm_pkg::SPM_S_DBL];
    end else begin
      if (ctrl_wr) begin
        ctrl_ff <= reg_wdata;
      end
      if (fault) begin
        ctrl_ff[spm_pkg::SPM_C_MASTER_SELECT] <= 1'b0;
      end
      if (stat_wr) begin
        dbl_ff <= reg_wdata[spm_pkg::SPM_S_DBL];
      end
    end
  end

////////////////////////////////////////////////////////////////////////
  // Master clock generator; rate bits read only here
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_ff <= spm_pkg::SPM_IDLE;
      div_ff <= 7'h00;
      edge_ff <= 4'h0;
      sck_lvl_ff <= 1'b0;
    end else begin
      unique case (state_ff)
        spm_pkg::SPM_IDLE: begin
          sck_lvl_ff <= clock_polarity;
          edge_ff <= 4'h0;
          div_ff <= spm_pkg::SPM_HALF_TBL[{dbl_ff, ctrl_ff[1:0]}];
          if (start) begin
            state_ff <= spm_pkg::SPM_RUN;
          end
        end
        spm_pkg::SPM_RUN: begin
          if (fault || !en || !master_select || mst_done) begin
            state_ff <= spm_pkg::SPM_IDLE;
          end
          if (tick) begin
            sck_lvl_ff <= !sck_lvl_ff;
            edge_ff <= edge_ff + 4'h1;
            div_ff <= spm_pkg::SPM_HALF_TBL[{dbl_ff, ctrl_ff[1:0]}];
          end else begin
            div_ff <= div_ff - 7'h01;
          end
        end
      endcase
    end
  end

////////////////////////////////////////////////////////////////////////
  // Shifter; partial slave byte is dropped but shift data kept
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      sh_ff <= 8'h00;
      cnt_ff <= 3'h0;
      slv_busy_ff <= 1'b0;
      rx_buf_ff <= 8'h00;
    end else begin
      if (load) begin
        sh_ff <= reg_wdata;
        cnt_ff <= 3'h0;
      end else if (sample_ev) begin
        sh_ff <= nxt_sh;
        cnt_ff <= cnt_ff + 3'h1;
      end
      if (done) begin
        rx_buf_ff <= nxt_sh;
      end
      if (!master_select && !slv_act) begin
        cnt_ff <= 3'h0;
        slv_busy_ff <= 1'b0;
      end else if (!slv_act || slv_done) begin
        slv_busy_ff <= 1'b0;
      end else if (sck_chg && lead_ev) begin
        // Leading edge only: the edge after the last sample must not re-arm
        slv_busy_ff <= 1'b1;
      end
      if (fault) begin
        cnt_ff <= 3'h0;
      end
    end
  end

  // Outgoing bit changes only on setup edges, or when idle in phase 0
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      tx_bit_ff <= 1'b0;
    end else if (start && !clock_phase) begin
      tx_bit_ff <= lsb_first ? reg_wdata[0] : reg_wdata[7];
    end else if (setup_ev || (!xfer_busy && !clock_phase && !master_select)) begin
      tx_bit_ff <= lsb_first ? sh_ff[0] : sh_ff[7];
    end
  end

////////////////////////////////////////////////////////////////////////
  // Set beats clear on both flags
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      done_ff <= 1'b0;
      write_collision_flag_ff <= 1'b0;
      arm_ff <= 1'b0;
    end else begin
      if (done || fault) begin
        done_ff <= 1'b1;
      end else if (irq_vector_ack || (arm_ff && data_acc)) begin
        done_ff <= 1'b0;
      end
      if (data_wr && xfer_busy) begin
        write_collision_flag_ff <= 1'b1;
      end else if (arm_ff && data_acc) begin
        write_collision_flag_ff <= 1'b0;
      end
      if (stat_rd && (done_ff || write_collision_flag_ff)) begin
        arm_ff <= 1'b1;
      end else if (data_acc) begin
        arm_ff <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata_ff <= 8'h00;
    end else if (reg_rd) begin
      unique case (reg_addr)
        spm_pkg::SPM_CTRL_OFS: rdata_ff <= ctrl_ff;
        spm_pkg::SPM_STAT_OFS: rdata_ff <= {done_ff, write_collision_flag_ff, 5'h00,
                                            dbl_ff};
        spm_pkg::SPM_DATA_OFS: rdata_ff <= rx_buf_ff;
        default: rdata_ff <= 8'h00;
      endcase
    end
  end

////////////////////////////////////////////////////////////////////////
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_ff <= 1'b0;
      sck_oe_ff <= 1'b0;
      mosi_oe_ff <= 1'b0;
      miso_oe_ff <= 1'b0;
    end else begin
      irq_ff <= done_ff && ctrl_ff[spm_pkg::SPM_C_IE] &&
                global_irq_en;
      sck_oe_ff <= en && master_select && !fault && sck_dir;
      mosi_oe_ff <= en && master_select && !fault && mosi_dir;
      miso_oe_ff <= slv_act && miso_dir;
    end
  end

  assign reg_rdata = rdata_ff;
  assign irq_req = irq_ff;
  assign sck_out = sck_lvl_ff;
  assign sck_oe = sck_oe_ff;
  assign mosi_out = tx_bit_ff;
  assign mosi_oe = mosi_oe_ff;
  assign miso_out = tx_bit_ff;
  assign miso_oe = miso_oe_ff;

////////////////////////////////////////////////////////////////////////
  default clocking spm_cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_b);

  sequence fast_start_s;
    start && dbl_ff && ctrl_ff[1:0] == 2'b00;
  endsequence
  sequence flag_up_s;
    done_ff && !run;
  endsequence

  stat_reserved_a: assert property (
    stat_rd |=> reg_rdata[5:1] == 5'h00)
    else $error("reserved status bits not zero");
  mode_fault_a: assert property (
    fault |=> !master_select && done_ff && !sck_oe)
    else $error("forced slave switch missing");
  irq_gate_a: assert property (
    done_ff && ctrl_ff[7] && global_irq_en |=> irq_req)
    else $error("interrupt not raised");
  disabled_idle_a: assert property (
    !en |=> !run && !slv_busy_ff)
    else $error("activity while disabled");
  ss_reset_a: assert property (
    !master_select && ss_b_s |=> cnt_ff == 3'h0 && !slv_busy_ff)
    else $error("slave logic not reset");
  write_collision_flag_set_a: assert property (
    data_wr && xfer_busy |=> write_collision_flag_ff && sh_ff == $past(nxt_sh))
    else $error("collision not flagged");
  byte_time_a: assert property (
    fast_start_s |=> run [*8] ##[8:9] flag_up_s)
    else $error("master byte time wrong");
  idle_level_a: assert property (
    master_select && !run && !$past(run) |-> sck_out == $past(clock_polarity))
    else $error("clock idle level wrong");
  order_first_a: assert property (
    start && !clock_phase |=> mosi_out ==
      ($past(lsb_first) ? $past(reg_wdata[0]) : $past(reg_wdata[7])))
    else $error("first bit order wrong");
  slave_rate_a: assert property (
    !master_select |=> !run)
    else $error("divider ran as slave");
endmodule // spm_port

// >>> common/spm_pkg.sv
/*
  Constants for the byte-wide serial port: register offsets, field
  positions, reset values, rate table and master sequencer states.
  Assumes an 8-bit register address space on a plain strobe port.
*/
package spm_pkg;
  localparam logic [7:0] SPM_CTRL_OFS = 8'h2C;
  localparam logic [7:0] SPM_STAT_OFS = 8'h2D;
  localparam logic [7:0] SPM_DATA_OFS = 8'h2E;
  localparam logic [7:0] SPM_CTRL_RST = 8'h00;
  localparam logic [7:0] SPM_STAT_RST = 8'h00;
  localparam int SPM_C_IE = 7;
  localparam int SPM_C_EN = 6;
  localparam int SPM_C_ORDER = 5;
  localparam int SPM_C_MASTER_SELECT = 4;
  localparam int SPM_C_CLOCK_POLARITY = 3;
  localparam int SPM_C_CLOCK_PHASE = 2;
  localparam int SPM_C_RATE_HI = 1;
  localparam int SPM_C_RATE_LO = 0;
  localparam int SPM_S_DONE = 7;
  localparam int SPM_S_WRITE_COLLISION_FLAG = 6;
  localparam int SPM_S_DBL = 0;
  // Last clock edge index and last bit index
  localparam logic [3:0] SPM_LAST_EDGE = 4'hF;
  localparam logic [2:0] SPM_LAST_BIT = 3'h7;
  // Half-period reload, index {double_speed, rate_hi, rate_lo}
  localparam logic [6:0] SPM_HALF_TBL [0:7] = '{
    7'h01, 7'h07, 7'h1F, 7'h3F, 7'h00, 7'h03, 7'h0F, 7'h1F};
  typedef enum logic [1:0] {
    SPM_IDLE = 2'b01,
    SPM_RUN = 2'b10
  } spm_mst_t;
endpackage

// >>> tb/spm_far_end.sv
/* Slave device model facing the port in master mode.
   Assumes mode 0, most significant bit first. */
`timescale 1ns/100ps
module spm_far_end (
  input wire logic sck,
  input wire logic mosi,
  input wire logic sel_b,
  input wire logic [7:0] tx_byte,
  output logic miso,
  output logic [7:0] rx_ff
);
  logic [7:0] sh_ff = 8'h00;
  logic last_ff = 1'b0;
  // Released line must not hold the last bit
  assign miso = sel_b ? ~last_ff : sh_ff[7];
  always @(negedge sel_b) sh_ff <= tx_byte;
  // A deselected device ignores the clock
  always @(posedge sck) begin
    if (!sel_b) begin
      rx_ff <= {rx_ff[6:0], mosi};
      last_ff <= sh_ff[7];
    end
  end
  always @(negedge sck) begin
    if (!sel_b) begin
      sh_ff <= {sh_ff[6:0], sh_ff[7]};
    end
  end
endmodule // spm_far_end

// >>> tb/tb.sv
/* Bench: registers, master transfers, rates, mode fault, slave.
   Assumes spm_pkg, spm_port and spm_far_end compile first. */
`timescale 1ns/100ps
module tb;
  localparam logic [7:0] CT = spm_pkg::SPM_CTRL_OFS;
  localparam logic [7:0] ST = spm_pkg::SPM_STAT_OFS;
  localparam logic [7:0] DT = spm_pkg::SPM_DATA_OFS;
  localparam logic [7:0] HALF [0:7] = '{8'h02, 8'h08, 8'h20, 8'h40,
    8'h01, 8'h04, 8'h10, 8'h20};
  logic core_clk, rst_b, reg_wr, reg_rd, global_irq_en, irq_vector_ack;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, far_rx;
  logic irq_req, sck_dir, mosi_dir, miso_dir, ss_dir, sck_in, sck_out;
  logic sck_oe, mosi_in, mosi_out, mosi_oe, miso_in, miso_out, miso_oe;
  logic ss_b_in, far_sel_b;
  int n_errors;
  int n_tests;
  spm_port u_dut (.core_clk, .rst_b, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .global_irq_en, .irq_vector_ack, .irq_req,
    .sck_dir, .mosi_dir, .miso_dir, .ss_dir, .sck_in, .sck_out, .sck_oe,
    .mosi_in, .mosi_out, .mosi_oe, .miso_in, .miso_out, .miso_oe,
    .ss_b_in);
  spm_far_end u_far (.sck(sck_out), .mosi(mosi_out), .sel_b(far_sel_b),
    .tx_byte(8'h35), .miso(miso_in), .rx_ff(far_rx));
  ////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
    @(posedge core_clk);
  endtask
  task automatic wait_done(output logic [7:0] s);
    s = 8'h00;
    for (int i = 0; i < 1500 && s[7] !== 1'b1; i++) rd(ST, s);
  endtask
  task automatic regs();
    logic [7:0] s;
    rd(CT, s);
    chk(s, spm_pkg::SPM_CTRL_RST);
    wr(ST, 8'hFF);
    rd(ST, s);
    chk(s, 8'h01);
    wr(ST, 8'h00);
    wr(8'h10, 8'hFF);
    rd(8'h10, s);
    chk(s, 8'h00);
  endtask
  // Second write lands mid-transfer on purpose
  task automatic xfer(input logic [7:0] c, d, ef, er);
    logic [7:0] s;
    far_sel_b <= 1'b0;
    ss_b_in <= 1'b0;
    wr(CT, c);
    wr(DT, d);
    wr(DT, 8'hFF);
    wait_done(s);
    chk(s, 8'hC0);
    rd(DT, s);
    chk(s, er);
    chk(far_rx, ef);
    far_sel_b <= 1'b1;
    ss_b_in <= 1'b1;
    rd(ST, s);
    chk(s, 8'h00);
  endtask
  task automatic rates();
    logic [7:0] s;
    int n;
    for (int r = 0; r < 8; r++) begin
      wr(ST, {7'h00, r[2]});
      wr(CT, {6'h14, r[1:0]});
      wr(DT, 8'h00);
      wait (sck_out);
      n = 0;
      while (sck_out === 1'b1) begin
        @(posedge core_clk);
        #1 n++;
      end
      chk(n[7:0], HALF[r]);
      wait_done(s);
      rd(DT, s);
    end
    wr(ST, 8'h00);
  endtask
  task automatic fault();
    logic [7:0] s;
    ss_dir <= 1'b0;
    global_irq_en <= 1'b1;
    wr(CT, 8'hD8);
    #1 chk({5'h00, sck_oe, mosi_oe, sck_out}, 8'h07);
    ss_b_in <= 1'b0;
    repeat (6) @(posedge core_clk);
    #1 chk({5'h00, irq_req, sck_oe, mosi_oe}, 8'h04);
    rd(CT, s);
    chk(s, 8'hC8);
    global_irq_en <= 1'b0;
    @(posedge core_clk);
    #1 chk({7'h00, irq_req}, 8'h00);
    global_irq_en <= 1'b1;
    irq_vector_ack <= 1'b1;
    @(posedge core_clk);
    irq_vector_ack <= 1'b0;
    repeat (3) @(posedge core_clk);
    #1 chk({7'h00, irq_req}, 8'h00);
    ss_b_in <= 1'b1;
  endtask
  // Outside master, 400 ns period, mode 0
  task automatic sbits(input logic [7:0] d, input int k,
    output logic [7:0] m);
    for (int i = 7; i > 7 - k; i--) begin
      mosi_in <= d[i];
      repeat (4) @(posedge core_clk);
      sck_in <= 1'b1;
      @(posedge core_clk);
      #1 m = {m[6:0], miso_out};
      repeat (3) @(posedge core_clk);
      sck_in <= 1'b0;
    end
  endtask
  task automatic slave();
    logic [7:0] s;
    ss_dir <= 1'b0;
    miso_dir <= 1'b1;
    wr(CT, 8'h40);
    ss_b_in <= 1'b0;
    repeat (6) @(posedge core_clk);
    sbits(8'hFF, 3, s);
    ss_b_in <= 1'b1;
    // Select must pass the synchroniser before the load, else collision
    repeat (4) @(posedge core_clk);
    #1 chk({7'h00, miso_oe}, 8'h00);
    wr(DT, 8'h5A);
    ss_b_in <= 1'b0;
    repeat (6) @(posedge core_clk);
    #1 chk({7'h00, miso_oe}, 8'h01);
    sbits(8'hC3, 8, s);
    chk(s, 8'h5A);
    repeat (6) @(posedge core_clk);
    rd(ST, s);
    chk(s, 8'h80);
    rd(DT, s);
    chk(s, 8'hC3);
  endtask
  task automatic results();
    $display("errors %0d tests %0d", n_errors, n_tests);
    if (n_errors == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  initial begin
    #2000000 n_errors++;
    results();
  end
  initial begin
    {rst_b, reg_wr, reg_rd, global_irq_en, irq_vector_ack} = '0;
    {reg_addr, reg_wdata, miso_dir, sck_in, mosi_in} = '0;
    {sck_dir, mosi_dir, ss_dir, ss_b_in, far_sel_b} = '1;
    n_errors = 0;
    n_tests = 0;
    repeat (10) @(posedge core_clk);
    rst_b <= 1'b1;
    @(posedge core_clk);
    regs();
    xfer(8'h51, 8'hA5, 8'hA5, 8'h35);
    xfer(8'h71, 8'h01, 8'h80, 8'hAC);
    rates();
    fault();
    slave();
    results();
  end
endmodule // tb
